//--- sim/l2sc_monitor.sv
`timescale 1ns/1ps
module l2sc_monitor import l2sc_pkg::*; (
    // apb
    input wire logic                     pclk,
    input wire logic                     presetn,
    input wire logic                     psel,
    input wire logic                     penable,
    input wire logic                     pwrite,
    input wire logic [PDATA_W-1:0]       prdata,
    input wire logic                     pready,
    input wire logic                     pslverr,
    // channels
    input wire logic [NCH-1:0]           ch_valid,
    input wire logic [NCH-1:0]           ch_ready,
    input wire logic [NCH-1:0]           ch_done,
    input wire logic [NPORT-1:0][DW-1:0] rd_data
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic [2:0] open_r;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) open_r <= '0;
        else open_r <= open_r + 3'(ch_valid[0] && ch_ready[0]) - 3'(ch_done[0]);
    end
    a_pready_pulse: assert property (pready |=> !pready) else $error("pready too long");
    a_apb_onewait: assert property (psel && penable && !pready |=> pready) else $error("no answer");
    a_ready_access: assert property (pready |-> $past(psel && penable)) else $error("stray pready");
    a_err_ready: assert property (pslverr |-> pready) else $error("pslverr alone");
    a_err_rdzero: assert property (pslverr && !pwrite |-> prdata == '0) else $error("error data");
    a_rd_hold: assert property ($changed(rd_data[0]) |-> ch_done[0])
        else $error("rd_data moved");
    a_done_taken: assert property (ch_done[0] |-> open_r != 3'd0)
        else $error("done without request");
    a_core_rd_lat: assert property (ch_valid[0] && ch_ready[0] && open_r == 3'd0
        |=> !ch_done[0] [*2] ##[1:300] ch_done[0]) else $error("core read latency");
endmodule // l2sc_monitor
bind l2sc_top l2sc_monitor u_mon (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr), .ch_valid(ch_valid),
    .ch_ready(ch_ready), .ch_done(ch_done), .rd_data(rd_data));

//--- sim/l2sc_xbar_model.sv
`timescale 1ns/1ps
module l2sc_xbar_model import l2sc_pkg::*; (
    // clock and reset
    input  wire logic                   pclk,
    input  wire logic                   presetn,
    // stream set-up
    input  wire logic     [NCH-1:0]     load,
    input  wire logic     [7:0]         num,
    input  wire l2sc_req_type           req,
    // channel side
    output logic          [NCH-1:0]     ch_valid,
    output l2sc_req_type  [NCH-1:0]     ch_req,
    input  wire logic     [NCH-1:0]     ch_ready
);
    logic [7:0] left_r [NCH];
    always_comb begin
        for (int c = 0; c < NCH; c++) ch_valid[c] = left_r[c] != 8'h00;
    end
    // one 8-byte word per handshake, held until taken
    always_ff @(posedge pclk or negedge presetn) begin
        for (int c = 0; c < NCH; c++) begin
            if (!presetn) begin
                left_r[c] <= 8'h00;
                ch_req[c] <= '0;
            end else if (load[c]) begin
                left_r[c] <= num;
                ch_req[c] <= req;
            end else if (ch_valid[c] && ch_ready[c]) begin
                left_r[c] <= left_r[c] - 8'h01;
                if (left_r[c] == 8'h01) ch_req[c] <= ~ch_req[c];
            end
        end
    end
endmodule // l2sc_xbar_model

//--- sim/test_l2sc_top.sv
`timescale 1ns/1ps
`define CHK(n, e, s) begin n_compared++; if ((s) !== (e)) begin err_total++; \
    $display("unexpected %s exp %0h got %0h", n, e, s); end end
module test_l2sc_top import l2sc_pkg::*;;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, er;
    logic [PADDR_W-1:0] paddr;
    logic [PDATA_W-1:0] pwdata, prdata, rd;
    logic [NCH-1:0] ch_valid, ch_ready, ch_done, load;
    l2sc_req_type [NCH-1:0] ch_req;
    l2sc_req_type req;
    logic [NPORT-1:0][DW-1:0] rd_data;
    logic [7:0] num;
    int err_total, n_compared, lp, lm, lw, n;
    logic [PADDR_W-1:0] offs [7] = '{OFF_RPC, OFF_WPC, OFF_PEN, OFF_CTRL, OFF_STAT, OFF_IEN, 12'h020};
    l2sc_top u_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .ch_valid(ch_valid), .ch_req(ch_req), .ch_ready(ch_ready), .ch_done(ch_done),
        .rd_data(rd_data), .irq(irq));
    l2sc_xbar_model u_xbar (.pclk(pclk), .presetn(presetn), .load(load), .num(num), .req(req),
        .ch_valid(ch_valid), .ch_req(ch_req), .ch_ready(ch_ready));
    task automatic apb(input logic w, input logic [PADDR_W-1:0] a, input logic [PDATA_W-1:0] d);
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    task automatic chk_reg(input logic [PADDR_W-1:0] a, input logic [PDATA_W-1:0] e, input logic ee);
        apb(1'b0, a, '0);
        `CHK("register data", e, rd)
        `CHK("register error", ee, er)
    endtask
    task automatic xfer(input int c, input logic [ADDR_W-1:0] a, input logic [DW-1:0] d,
                        input logic [SW-1:0] s, output int l);
        @(posedge pclk);
        {load, num, req} <= {NCH'(1 << c), 8'd1, a, d, s};
        @(posedge pclk);
        load <= '0;
        l = 0;
        @(negedge pclk);
        while (ch_done[c] !== 1'b1) begin
            l++;
            @(negedge pclk);
        end
    endtask
    task automatic tally_and_finish;
        if (err_total == 0 && n_compared > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    initial begin
        repeat (5000) @(posedge pclk);
        err_total++;
        tally_and_finish;
    end
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, load, num, req} = '0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        foreach (offs[i]) chk_reg(offs[i], 32'h0000_0000, offs[i] == 12'h020);
        apb(1'b1, OFF_RPC, 32'h0000_0100);
        apb(1'b1, OFF_WPC, 32'h0000_0100);
        chk_reg(OFF_RPC, 32'h0000_0100, 1'b0);
        apb(1'b1, OFF_IEN, 32'h0000_0003);
        apb(1'b1, OFF_STAT, 32'hFFFF_FFFF);
        apb(1'b1, OFF_CLR, 32'h0000_0003);
        chk_reg(OFF_CLR, 32'h0000_0000, 1'b0);
        xfer(1, 16'h0008, 64'h1122_3344_5566_7788, 8'hFF, lp);
        apb(1'b1, OFF_PEN, 32'h0000_0002);
        xfer(1, 16'h0008, 64'h0000_0000_0000_00AA, 8'h01, lm);
        `CHK("rmw extra", 2, lm - lp)
        xfer(1, 16'h0008, 64'h9999_9999_0000_0000, 8'hF0, lw);
        `CHK("aligned latency", lp, lw)
        xfer(0, 16'h0008, '0, '0, lw);
        `CHK("core read", 64'h9999_9999_5566_77AA, rd_data[0])
        chk_reg(OFF_STAT, 32'h0000_0000, 1'b0);
        `CHK("irq", 1'b0, irq)
        xfer(3, 16'h000C, 64'h0000_0000_1234_5678, 8'h0F, lw);
        xfer(2, 16'h000C, '0, '0, lw);
        `CHK("narrow dma", 64'h0000_0000_1234_5678, rd_data[1])
        apb(1'b1, OFF_CTRL, 32'h0000_0001);
        xfer(2, 16'h0008, '0, '0, lw);
        `CHK("wide dma", 64'h1234_5678_5566_77AA, rd_data[1])
        @(posedge pclk);
        {load, num, req} <= {4'b0101, 8'd40, 88'h0};
        @(posedge pclk);
        load <= '0;
        repeat (10) @(posedge pclk);
        n = 0;
        repeat (30) begin
            @(negedge pclk);
            if (ch_done[2] === 1'b1) n++;
        end
        `CHK("dma share", 10, n)
        repeat (150) @(posedge pclk);
        tally_and_finish;
    end
endmodule // test_l2sc_top

//--- verilog/l2sc_bank.sv
`timescale 1ns/1ps
module l2sc_bank import l2sc_pkg::*; #(
    parameter int DEPTH = 2 ** IDX_W
) (
    // clock and reset
    input  wire logic             pclk,
    input  wire logic             presetn,
    // per-bank parity enable
    input  wire logic             par_en,
    // read port
    input  wire logic             re,
    input  wire logic [IDX_W-1:0] raddr,
    output logic      [DW-1:0]    rdata,
    output logic                  perr,
    // write port
    input  wire logic             we,
    input  wire logic [IDX_W-1:0] waddr,
    input  wire logic [DW-1:0]    wdata,
    input  wire logic [SW-1:0]    wstrb,
    output logic      [DW-1:0]    peek
);
    logic [DW-1:0]    mem [DEPTH];
    logic [NLANE-1:0] par [DEPTH];
    logic [DW-1:0]    rdata_r;
    logic [NLANE-1:0] rpar_r;
    logic             rchk_r;
    logic [DW-1:0]    merged;

    assign peek   = mem[waddr];
    assign merged = l2sc_merge(peek, wdata, wstrb);
    assign rdata  = rdata_r;

    // parity kept per 32-bit lane, refreshed for every lane touched
    always_ff @(posedge pclk) begin
        if (we) begin
            mem[waddr] <= merged;
            for (int l = 0; l < NLANE; l++) begin
                if (|wstrb[l*LANE_B +: LANE_B]) begin
                    par[waddr][l] <= ^merged[l*LANE_W +: LANE_W];
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_r <= '0;
            rpar_r  <= '0;
            rchk_r  <= 1'b0;
        end else if (re) begin
            rdata_r <= mem[raddr];
            rpar_r  <= par[raddr];
            rchk_r  <= par_en;
        end
    end

    always_comb begin
        perr = 1'b0;
        for (int l = 0; l < NLANE; l++) begin
            if (rchk_r && ((^rdata_r[l*LANE_W +: LANE_W]) != rpar_r[l])) begin
                perr = 1'b1;
            end
        end
    end
endmodule // l2sc_bank

//--- verilog/l2sc_pkg.sv
package l2sc_pkg;
    // address map of the array: 8-byte words interleaved over the banks
    localparam int ADDR_W       = 16;
    localparam int DW           = 64;
    localparam int SW           = 8;
    localparam int LANE_W       = 32;
    localparam int LANE_B       = 4;
    localparam int NLANE        = 2;
    localparam int LANE_SEL_BIT = 2;
    localparam int NBANK        = 8;
    localparam int BANK_W       = 3;
    localparam int BANK_LSB     = 3;
    localparam int IDX_LSB      = BANK_LSB + BANK_W;
    localparam int IDX_W        = ADDR_W - IDX_LSB;

    // channels: index = 2 * port + direction
    localparam int NPORT     = 2;
    localparam int NCH       = 4;
    localparam int PORT_CORE = 0;
    localparam int PORT_DMA  = 1;
    localparam int DIR_RD    = 0;
    localparam int DIR_WR    = 1;
    localparam int QDEPTH    = 2;
    localparam int QPTR_W    = 1;
    localparam int QCNT_W    = 2;
    localparam int PCNT_W    = 4;
    localparam logic TURN_CORE = 1'b0;
    localparam logic TURN_DMA  = 1'b1;

    // register bus
    localparam int PADDR_W = 12;
    localparam int PDATA_W = 32;
    localparam logic [PADDR_W-1:0] OFF_RPC  = 12'h000;
    localparam logic [PADDR_W-1:0] OFF_WPC  = 12'h004;
    localparam logic [PADDR_W-1:0] OFF_PEN  = 12'h008;
    localparam logic [PADDR_W-1:0] OFF_CTRL = 12'h00C;
    localparam logic [PADDR_W-1:0] OFF_STAT = 12'h010;
    localparam logic [PADDR_W-1:0] OFF_CLR  = 12'h014;
    localparam logic [PADDR_W-1:0] OFF_IEN  = 12'h018;
    localparam int CORE_CNT_LSB   = 0;
    localparam int DMA_CNT_LSB    = 8;
    localparam int CTRL_HSDMA_BIT = 0;
    localparam int NEV            = 2;
    localparam int EV_CORE_PERR   = 0;
    localparam int EV_DMA_PERR    = 1;
    localparam logic [PCNT_W-1:0] PCNT_RST = 4'h0;
    localparam logic [NBANK-1:0]  PEN_RST  = 8'h00;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DW-1:0]     wdata;
        logic [SW-1:0]     strb;
    } l2sc_req_type;

    typedef enum logic [1:0] {
        WR_IDLE = 2'b00,
        WR_RD1  = 2'b01,
        WR_RD2  = 2'b10
    } l2sc_wst_type;

    function automatic logic [BANK_W-1:0] l2sc_bank_of(input logic [ADDR_W-1:0] a);
        return a[BANK_LSB +: BANK_W];
    endfunction

    function automatic logic [IDX_W-1:0] l2sc_idx_of(input logic [ADDR_W-1:0] a);
        return a[IDX_LSB +: IDX_W];
    endfunction

    function automatic logic [DW-1:0] l2sc_merge(input logic [DW-1:0] old, input logic [DW-1:0] nw,
                                                 input logic [SW-1:0] strb);
        logic [DW-1:0] m;
        m = old;
        for (int i = 0; i < SW; i++) begin
            if (strb[i]) begin
                m[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return m;
    endfunction

    // true when some 32-bit lane is only partly written
    function automatic logic l2sc_partial(input logic [SW-1:0] strb);
        logic p;
        p = 1'b0;
        for (int l = 0; l < NLANE; l++) begin
            if (strb[l*LANE_B +: LANE_B] != '0 && strb[l*LANE_B +: LANE_B] != '1) begin
                p = 1'b1;
            end
        end
        return p;
    endfunction
endpackage

//--- verilog/l2sc_top.sv
// Register access over APB and the register addresses were left to the implementer.
`timescale 1ns/1ps
// Overview of operation
// - Port 0 carries 64-bit core traffic and port 1 carries 32-bit DMA traffic.
// - In high speed memory DMA mode the DMA port uses the full 64-bit path.
// - Each port has its own read and write channel, and all four run in parallel on different banks.
// - Every access, whatever its size, becomes one 8-byte access to the array.
// - The array is eight banks with one parity bit per 32-bit lane, enabled bank by bank.
// - A byte or halfword write to a parity bank is a read of the word then a write, two cycles longer.
// - Writes to parity-off banks and whole 32/64-bit aligned writes go straight in with no read.
// - Throughput does not depend on whether addresses are sequential.
// - Core/DMA clashes on one bank are settled by separate read and write priority counts.
// - With core counts 0 and DMA counts 1 the DMA gets one access every three cycles in a clash.
// - Controller and array run on the system clock, at most half the core clock.
module l2sc_top import l2sc_pkg::*; (
    // apb register bus, pclk is the system clock
    input  wire logic                     pclk,
    input  wire logic                     presetn,
    input  wire logic     [PADDR_W-1:0]   paddr,
    input  wire logic                     psel,
    input  wire logic                     penable,
    input  wire logic                     pwrite,
    input  wire logic     [PDATA_W-1:0]   pwdata,
    output logic          [PDATA_W-1:0]   prdata,
    output logic                          pready,
    output logic                          pslverr,
    // channel requests, index 2*port+dir
    input  wire logic     [NCH-1:0]       ch_valid,
    input  wire l2sc_req_type [NCH-1:0]   ch_req,
    output logic          [NCH-1:0]       ch_ready,
    // completions
    output logic          [NCH-1:0]       ch_done,
    output logic          [NPORT-1:0][DW-1:0] rd_data,
    // interrupt
    output logic                          irq
);
    // registers
    logic [PCNT_W-1:0]  rpc_core_r, rpc_dma_r, wpc_core_r, wpc_dma_r;
    logic [NBANK-1:0]   pen_r;
    logic               hsdma_r;
    logic [NEV-1:0]     status_r, ien_r, status_nxt, clr, ev;
    logic               irq_r;
    logic [PDATA_W-1:0] prdata_r, apb_rdata;
    logic               pready_r, pslverr_r, apb_hit, apb_acc, apb_wr;
    // queues
    l2sc_req_type       q_r [NCH][QDEPTH];
    l2sc_req_type [NCH-1:0] inreq, head;
    logic [QPTR_W-1:0]  wp_r [NCH];
    logic [QPTR_W-1:0]  rp_r [NCH];
    logic [QCNT_W-1:0]  cnt_r [NCH];
    logic [QCNT_W-1:0]  cnt_nxt [NCH];
    logic [NCH-1:0]     ready_r, push, pop, want, gnt, ch_done_r;
    // arbitration per direction and bank
    logic               turn_r [NPORT][NBANK];
    logic               turn_nxt [NPORT][NBANK];
    logic               gap_r [NPORT][NBANK];
    logic               gap_nxt [NPORT][NBANK];
    logic [PCNT_W-1:0]  acnt_r [NPORT][NBANK];
    logic [PCNT_W-1:0]  acnt_nxt [NPORT][NBANK];
    logic [PCNT_W-1:0]  cc, dc;
    logic               rq_c, rq_d;
    // write sequencing
    l2sc_wst_type       wst_r [NPORT];
    logic [DW-1:0]      rmw_r [NPORT];
    logic [NPORT-1:0]   rmw_need;
    // read return
    logic [NPORT-1:0]   rd_pend_r, rd_lane_r, rd_nar_r;
    logic [BANK_W-1:0]  rd_bank_r [NPORT];
    logic [NPORT-1:0][DW-1:0] rd_data_r;
    // bank ports
    logic [NBANK-1:0]   bk_re, bk_we, bk_perr;
    logic [IDX_W-1:0]   bk_raddr [NBANK];
    logic [IDX_W-1:0]   bk_waddr [NBANK];
    logic [DW-1:0]      bk_wdata [NBANK];
    logic [SW-1:0]      bk_wstrb [NBANK];
    logic [DW-1:0]      bk_rdata [NBANK];
    logic [DW-1:0]      bk_peek [NBANK];

    function automatic logic [PDATA_W-1:0] pc_word(input logic [PCNT_W-1:0] core, input logic [PCNT_W-1:0] dma);
        logic [PDATA_W-1:0] w;
        w = '0;
        w[CORE_CNT_LSB +: PCNT_W] = core;
        w[DMA_CNT_LSB +: PCNT_W]  = dma;
        return w;
    endfunction

    // apb slave: access phase lasts two cycles, pready from a flop
    assign apb_acc = psel && penable && !pready_r;
    assign apb_wr  = psel && penable && pready_r && pwrite && !pslverr_r;

    always_comb begin
        apb_rdata = '0;
        apb_hit   = 1'b1;
        case (paddr)
            OFF_RPC:  apb_rdata = pc_word(rpc_core_r, rpc_dma_r);
            OFF_WPC:  apb_rdata = pc_word(wpc_core_r, wpc_dma_r);
            OFF_PEN:  apb_rdata[NBANK-1:0] = pen_r;
            OFF_CTRL: apb_rdata[CTRL_HSDMA_BIT] = hsdma_r;
            OFF_STAT: apb_rdata[NEV-1:0] = status_r;
            OFF_CLR:  apb_rdata = '0;
            OFF_IEN:  apb_rdata[NEV-1:0] = ien_r;
            default:  apb_hit = 1'b0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= '0;
        end else begin
            pready_r <= apb_acc;
            if (apb_acc) begin
                pslverr_r <= !apb_hit;
                prdata_r  <= pwrite ? '0 : apb_rdata;
            end else begin
                pslverr_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rpc_core_r <= PCNT_RST;
            rpc_dma_r  <= PCNT_RST;
            wpc_core_r <= PCNT_RST;
            wpc_dma_r  <= PCNT_RST;
            pen_r      <= PEN_RST;
            hsdma_r    <= 1'b0;
            ien_r      <= '0;
        end else if (apb_wr) begin
            case (paddr)
                OFF_RPC: begin
                    rpc_core_r <= pwdata[CORE_CNT_LSB +: PCNT_W];
                    rpc_dma_r  <= pwdata[DMA_CNT_LSB +: PCNT_W];
                end
                OFF_WPC: begin
                    wpc_core_r <= pwdata[CORE_CNT_LSB +: PCNT_W];
                    wpc_dma_r  <= pwdata[DMA_CNT_LSB +: PCNT_W];
                end
                OFF_PEN:  pen_r   <= pwdata[NBANK-1:0];
                OFF_CTRL: hsdma_r <= pwdata[CTRL_HSDMA_BIT];
                OFF_IEN:  ien_r   <= pwdata[NEV-1:0];
                default: ;
            endcase
        end
    end

    // sticky status, a new event beats a clear in the same cycle
    assign clr        = (apb_wr && paddr == OFF_CLR) ? pwdata[NEV-1:0] : '0;
    assign status_nxt = (status_r & ~clr) | ev;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_r <= '0;
            irq_r    <= 1'b0;
        end else begin
            status_r <= status_nxt;
            irq_r    <= |(status_nxt & ien_r);
        end
    end

    // narrow dma data sits in the lane named by address bit 2
    always_comb begin
        for (int c = 0; c < NCH; c++) begin
            inreq[c] = ch_req[c];
            if (c / NPORT == PORT_DMA && !hsdma_r) begin
                inreq[c].wdata = {NLANE{ch_req[c].wdata[LANE_W-1:0]}};
                inreq[c].strb  = ch_req[c].addr[LANE_SEL_BIT] ?
                                 {ch_req[c].strb[LANE_B-1:0], {LANE_B{1'b0}}} :
                                 {{LANE_B{1'b0}}, ch_req[c].strb[LANE_B-1:0]};
            end
            head[c]    = q_r[c][rp_r[c]];
            want[c]    = cnt_r[c] != '0;
            push[c]    = ch_valid[c] && ready_r[c];
            cnt_nxt[c] = cnt_r[c] + QCNT_W'(push[c]) - QCNT_W'(pop[c]);
        end
    end

    // one request queue per channel, so channels on different banks never block one another
    always_ff @(posedge pclk) begin
        for (int c = 0; c < NCH; c++) begin
            if (push[c]) begin
                q_r[c][wp_r[c]] <= inreq[c];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ready_r <= '1;
            for (int c = 0; c < NCH; c++) begin
                wp_r[c]  <= '0;
                rp_r[c]  <= '0;
                cnt_r[c] <= '0;
            end
        end else begin
            for (int c = 0; c < NCH; c++) begin
                wp_r[c]    <= wp_r[c] + QPTR_W'(push[c]);
                rp_r[c]    <= rp_r[c] + QPTR_W'(pop[c]);
                cnt_r[c]   <= cnt_nxt[c];
                ready_r[c] <= cnt_nxt[c] != QCNT_W'(QDEPTH);
            end
        end
    end

    // per bank and direction grant; a clash uses the priority counts
    always_comb begin
        gnt      = '0;
        turn_nxt = turn_r;
        gap_nxt  = gap_r;
        acnt_nxt = acnt_r;
        cc       = '0;
        dc       = '0;
        rq_c     = 1'b0;
        rq_d     = 1'b0;
        for (int d = 0; d < NPORT; d++) begin
            cc = (d == DIR_RD) ? rpc_core_r : wpc_core_r;
            dc = (d == DIR_RD) ? rpc_dma_r : wpc_dma_r;
            for (int b = 0; b < NBANK; b++) begin
                rq_c = want[d] && l2sc_bank_of(head[d].addr) == BANK_W'(b);
                rq_d = want[NPORT + d] && l2sc_bank_of(head[NPORT + d].addr) == BANK_W'(b);
                if (d == DIR_WR && rq_c && wst_r[PORT_CORE] != WR_IDLE) begin
                    gnt[d] = 1'b1;
                end else if (d == DIR_WR && rq_d && wst_r[PORT_DMA] != WR_IDLE) begin
                    gnt[NPORT + d] = 1'b1;
                end else if (rq_c && rq_d) begin
                    if (gap_r[d][b]) begin
                        gap_nxt[d][b] = 1'b0;
                    end else if (turn_r[d][b] == TURN_CORE || dc == '0) begin
                        gnt[d]         = 1'b1;
                        turn_nxt[d][b] = TURN_CORE;
                        if (acnt_r[d][b] >= cc) begin
                            acnt_nxt[d][b] = '0;
                            if (dc != '0) begin
                                turn_nxt[d][b] = TURN_DMA;
                                gap_nxt[d][b]  = 1'b1;
                            end
                        end else begin
                            acnt_nxt[d][b] = acnt_r[d][b] + PCNT_W'(1);
                        end
                    end else begin
                        gnt[NPORT + d] = 1'b1;
                        if (acnt_r[d][b] >= dc - PCNT_W'(1)) begin
                            acnt_nxt[d][b] = '0;
                            turn_nxt[d][b] = TURN_CORE;
                        end else begin
                            acnt_nxt[d][b] = acnt_r[d][b] + PCNT_W'(1);
                        end
                    end
                end else if (rq_c) begin
                    gnt[d] = 1'b1;
                end else if (rq_d) begin
                    gnt[NPORT + d] = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int d = 0; d < NPORT; d++) begin
                for (int b = 0; b < NBANK; b++) begin
                    turn_r[d][b] <= TURN_CORE;
                    gap_r[d][b]  <= 1'b0;
                    acnt_r[d][b] <= '0;
                end
            end
        end else begin
            turn_r <= turn_nxt;
            gap_r  <= gap_nxt;
            acnt_r <= acnt_nxt;
        end
    end

    // partial-lane writes to parity banks go through two read cycles
    always_comb begin
        for (int p = 0; p < NPORT; p++) begin
            rmw_need[p] = pen_r[l2sc_bank_of(head[2*p+1].addr)] && l2sc_partial(head[2*p+1].strb);
            pop[2*p]    = gnt[2*p];
            pop[2*p+1]  = gnt[2*p+1] && (wst_r[p] == WR_RD2 || (wst_r[p] == WR_IDLE && !rmw_need[p]));
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int p = 0; p < NPORT; p++) begin
                wst_r[p] <= WR_IDLE;
                rmw_r[p] <= '0;
            end
        end else begin
            for (int p = 0; p < NPORT; p++) begin
                unique case (wst_r[p])
                    WR_IDLE: begin
                        if (gnt[2*p+1] && rmw_need[p]) begin
                            wst_r[p] <= WR_RD1;
                        end
                    end
                    WR_RD1: begin
                        wst_r[p] <= WR_RD2;
                        rmw_r[p] <= bk_peek[l2sc_bank_of(head[2*p+1].addr)];
                    end
                    WR_RD2:  wst_r[p] <= WR_IDLE;
                    default: wst_r[p] <= WR_IDLE;
                endcase
            end
        end
    end

    // steer granted channels onto the bank ports
    always_comb begin
        for (int b = 0; b < NBANK; b++) begin
            bk_re[b]    = 1'b0;
            bk_we[b]    = 1'b0;
            bk_raddr[b] = '0;
            bk_waddr[b] = '0;
            bk_wdata[b] = '0;
            bk_wstrb[b] = '0;
            for (int p = 0; p < NPORT; p++) begin
                if (gnt[2*p] && l2sc_bank_of(head[2*p].addr) == BANK_W'(b)) begin
                    bk_re[b]    = 1'b1;
                    bk_raddr[b] = l2sc_idx_of(head[2*p].addr);
                end
                // index also steers the old-word read of a merge
                if (gnt[2*p+1] && l2sc_bank_of(head[2*p+1].addr) == BANK_W'(b)) begin
                    bk_we[b]    = pop[2*p+1];
                    bk_waddr[b] = l2sc_idx_of(head[2*p+1].addr);
                    bk_wdata[b] = head[2*p+1].wdata;
                    bk_wstrb[b] = head[2*p+1].strb;
                    if (wst_r[p] == WR_RD2) begin
                        bk_wdata[b] = l2sc_merge(rmw_r[p], head[2*p+1].wdata, head[2*p+1].strb);
                        bk_wstrb[b] = '1;
                    end
                end
            end
        end
    end

    for (genvar b = 0; b < NBANK; b++) begin : g_bank
        l2sc_bank u_bank (
            .pclk    (pclk),
            .presetn (presetn),
            .par_en  (pen_r[b]),
            .re      (bk_re[b]),
            .raddr   (bk_raddr[b]),
            .rdata   (bk_rdata[b]),
            .perr    (bk_perr[b]),
            .we      (bk_we[b]),
            .waddr   (bk_waddr[b]),
            .wdata   (bk_wdata[b]),
            .wstrb   (bk_wstrb[b]),
            .peek    (bk_peek[b])
        );
    end

    always_comb begin
        ev = '0;
        ev[EV_CORE_PERR] = rd_pend_r[PORT_CORE] && bk_perr[rd_bank_r[PORT_CORE]];
        ev[EV_DMA_PERR]  = rd_pend_r[PORT_DMA] && bk_perr[rd_bank_r[PORT_DMA]];
    end

    // read return and completion pulses
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_pend_r <= '0;
            rd_lane_r <= '0;
            rd_nar_r  <= '0;
            rd_data_r <= '0;
            ch_done_r <= '0;
            for (int p = 0; p < NPORT; p++) begin
                rd_bank_r[p] <= '0;
            end
        end else begin
            for (int p = 0; p < NPORT; p++) begin
                rd_pend_r[p]    <= gnt[2*p];
                rd_bank_r[p]    <= l2sc_bank_of(head[2*p].addr);
                rd_lane_r[p]    <= head[2*p].addr[LANE_SEL_BIT];
                rd_nar_r[p]     <= p == PORT_DMA && !hsdma_r;
                ch_done_r[2*p]   <= rd_pend_r[p];
                ch_done_r[2*p+1] <= pop[2*p+1];
                if (rd_pend_r[p]) begin
                    rd_data_r[p] <= bk_rdata[rd_bank_r[p]];
                    if (rd_nar_r[p]) begin
                        rd_data_r[p] <= {{LANE_W{1'b0}}, bk_rdata[rd_bank_r[p]][rd_lane_r[p]*LANE_W +: LANE_W]};
                    end
                end
            end
        end
    end

    assign prdata   = prdata_r;
    assign pready   = pready_r;
    assign pslverr  = pslverr_r;
    assign ch_ready = ready_r;
    assign ch_done  = ch_done_r;
    assign rd_data  = rd_data_r;
    assign irq      = irq_r;
endmodule // l2sc_top
